/* src/amg_cfg.svh */
// Constants for the alert mask and multipurpose pin configuration block.
`ifndef AMG_CFG_SVH
`define AMG_CFG_SVH

// ----------------------------------------------------------------------
// Command codes and reset values
// ----------------------------------------------------------------------
`define AMG_CMD_MASK_A     8'hd5
`define AMG_CMD_MASK_B     8'hd6
`define AMG_RESET_MASK_A   16'h8000
`define AMG_RESET_MASK_B   16'h0004

// ----------------------------------------------------------------------
// Field positions inside each alert mask
// ----------------------------------------------------------------------
`define AMG_POL_BIT        0
`define AMG_FUNC_LSB       1
`define AMG_FUNC_MSB       2
`define AMG_SRC_LSB        3
`define AMG_SRC_MSB        15
`define AMG_SRC_W          13

// Enable positions, one per status source.
`define AMG_EN_PASS_FAULT  15
`define AMG_EN_CUR_FAULT   14
`define AMG_EN_SOV_FAULT   13
`define AMG_EN_SUV_FAULT   12
`define AMG_EN_COMM_FAULT  11
`define AMG_EN_CUR_WARN    10
`define AMG_EN_CUR2_WARN   9
`define AMG_EN_SOV_WARN    8
`define AMG_EN_SUV_WARN    7
`define AMG_EN_AOV_WARN    6
`define AMG_EN_AUV_WARN    5
`define AMG_EN_INRUSH      4
`define AMG_EN_PWR_WARN    3

// ----------------------------------------------------------------------
// Pin function codes
// ----------------------------------------------------------------------
`define AMG_FUNC_ALERT     2'h0
`define AMG_FUNC_GPO       2'h1
`define AMG_FUNC_ALT       2'h2
`define AMG_FUNC_COMPARE   2'h3

`endif

/* src/amg_pkg.sv */
// Types shared by the alert mask and multipurpose pin configuration block.
package amg_pkg;

  // Status sources, most significant first, matching mask bits 15..3.
  typedef struct packed {
    logic pass_device_fault;
    logic current_over_fault;
    logic supply_over_fault;
    logic supply_under_fault;
    logic comm_logic_fault;
    logic current_over_warn;
    logic current_second_warn;
    logic supply_over_warn;
    logic supply_under_warn;
    logic aux_over_warn;
    logic aux_under_warn;
    logic inrush_limit_fault;
    logic input_power_over_warn;
  } amg_src_type;

  // One decoded command from the PMBus engine.
  typedef struct packed {
    logic        write;
    logic [7:0]  code;
    logic [15:0] data;
  } amg_cmd_type;

  // Pin drive: level and output enable.
  typedef struct packed {
    logic out;
    logic oe;
  } amg_pin_type;

  typedef enum logic {
    AMG_IDLE,
    AMG_ANSWER
  } amg_state_type;

endpackage : amg_pkg

/* src/amg_pin_drive.sv */
// Drive logic for one multipurpose alert pin.
`timescale 1ns/1ps
`default_nettype none
`include "amg_cfg.svh"

module amg_pin_drive
  import amg_pkg::*;
#(
  parameter bit ALT_IS_INPUT = 1'b1
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [1:0]  function_sel,
  input  wire logic        polarity,
  input  wire logic        latched_hit,
  input  wire logic        live_hit,
  input  wire logic        alt_level,
  output amg_pin_type      pin,
  output logic             asserted
);

  // --------------------------------------------------------------------
  // Next pin state
  // --------------------------------------------------------------------
  // Alert style outputs are open drain and active low.
  wire logic is_alert   = (function_sel == `AMG_FUNC_ALERT);
  wire logic is_gpo     = (function_sel == `AMG_FUNC_GPO);
  wire logic is_alt     = (function_sel == `AMG_FUNC_ALT);
  wire logic is_compare = (function_sel == `AMG_FUNC_COMPARE);

  wire logic alt_assert = is_alt & ~ALT_IS_INPUT & alt_level;
  wire logic act_d      = (is_alert & latched_hit) |
                          (is_compare & live_hit) | alt_assert;

  amg_pin_type pin_d;
  assign pin_d.out = is_gpo ? polarity : 1'b0;
  assign pin_d.oe  = is_gpo | act_d;

  amg_pin_type pin_q;
  logic        act_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      pin_q <= '0;
      act_q <= 1'b0;
    end else begin
      pin_q <= pin_d;
      act_q <= act_d;
    end
  end

  assign pin      = pin_q;
  assign asserted = act_q;

endmodule // amg_pin_drive
`default_nettype wire

/* src/amg_alert_cfg.sv */
// Alert masks and multipurpose pin configuration with command access.
//
// Function
// - Mask A bit 3 resets 0; when set, input power warning raises alert.
// - Pin A function bits 2:1 reset 00; 00 gives latched alert output.
// - Pin A function 01: plain output, level set by the polarity bit.
// - Pin A function 10: pin is a conversion trigger input, not driven.
// - Pin A function 11: pin follows live unlatched selected conditions.
// - Polarity bit 0 resets 0; 0 drives low, 1 drives high in output mode.
// - Mask B answers command 0xd6 and resets to 0x0004.
// - Mask B bit 15 enables pass device fault onto alert B.
// - Mask B bit 14 enables output overcurrent fault onto alert B.
// - Mask B bit 13 enables input overvoltage fault onto alert B.
// - Mask B bit 12 enables input undervoltage fault onto alert B.
// - Mask B bit 11 enables communication or logic fault onto alert B.
// - Mask B bit 10 enables output overcurrent warning onto alert B.
// - Mask B bit 9 enables second current warning onto alert B.
// - Mask B bit 8 enables input overvoltage warning onto alert B.
// - Mask A answers command 0xd5, resets 0x8000, pass fault enabled.
// - Mask B function resets to 10, the retry fail output.
`timescale 1ns/1ps
`default_nettype none
`include "amg_cfg.svh"

module amg_alert_cfg
  import amg_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        cmd_valid,
  input  wire amg_cmd_type cmd,
  output logic             cmd_ready,
  output logic             rsp_valid,
  output logic [15:0]      rsp_data,
  output logic             rsp_error,
  input  wire amg_src_type status_latched,
  input  wire amg_src_type status_live,
  input  wire logic        retry_fail,
  input  wire logic        multipin_a_in,
  output amg_pin_type      multipin_a,
  output amg_pin_type      multipin_b,
  output logic             convert_trigger_in,
  output logic             alert_a_active,
  output logic             alert_b_active,
  output logic [1:0]       multipin_a_function,
  output logic [1:0]       multipin_b_function
);

  // --------------------------------------------------------------------
  // Command handshake
  // --------------------------------------------------------------------
  // A command is taken in idle; its answer appears the next cycle.
  // Ready drops for the answer cycle, so commands come at most one in two
  // cycles, and a request still held when ready returns is taken again.
  amg_state_type state_q;
  amg_state_type state_d;
  amg_cmd_type   cmd_q;

  wire logic take = cmd_valid & (state_q == AMG_IDLE);

  always_comb begin
    state_d = state_q;
    case (state_q)
      AMG_IDLE: begin
        if (cmd_valid) begin
          state_d = AMG_ANSWER;
        end
      end
      AMG_ANSWER: begin
        state_d = AMG_IDLE;
      end
      default: begin
        state_d = AMG_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= AMG_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cmd_q <= '0;
    end else if (take) begin
      cmd_q <= cmd;
    end
  end

  assign cmd_ready = (state_q == AMG_IDLE);
  assign rsp_valid = (state_q == AMG_ANSWER);

  // --------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------
  // Decode uses the live command word, which is valid only in the taking
  // cycle; every strobe below is qualified by take for that reason.
  wire logic hit_a;
  wire logic hit_b;
  wire logic hit_none;

  assign hit_a    = (cmd.code == `AMG_CMD_MASK_A);
  assign hit_b    = (cmd.code == `AMG_CMD_MASK_B);
  assign hit_none = ~hit_a & ~hit_b;

  wire logic wr_a = take & cmd.write & hit_a;
  wire logic wr_b = take & cmd.write & hit_b;

  // --------------------------------------------------------------------
  // Alert mask registers
  // --------------------------------------------------------------------
  // Each mask is written as one whole word; there is no partial access,
  // so a write always replaces the function field and polarity as well.
  logic [15:0] alert_mask_a_q;
  logic [15:0] alert_mask_b_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      alert_mask_a_q <= `AMG_RESET_MASK_A;
    end else if (wr_a) begin
      alert_mask_a_q <= cmd.data;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      alert_mask_b_q <= `AMG_RESET_MASK_B;
    end else if (wr_b) begin
      alert_mask_b_q <= cmd.data;
    end
  end

  // --------------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------------
  // Read data is the value held when the command was taken.
  logic [15:0] rdata_d;
  logic [15:0] rdata_q;
  logic        err_q;
  wire  logic [15:0] rsp_value_d;
  wire  logic        rsp_err_d;

  always_comb begin
    if (hit_a) begin
      rdata_d = alert_mask_a_q;
    end else if (hit_b) begin
      rdata_d = alert_mask_b_q;
    end else begin
      rdata_d = 16'h0000;
    end
  end

  // --------------------------------------------------------------------
  // Response shaping
  // --------------------------------------------------------------------
  // Writes answer with zero data; an unknown code flags an error for both
  // reads and writes, and a write to it is dropped.
  assign rsp_value_d = cmd.write ? 16'h0000 : rdata_d;
  assign rsp_err_d   = hit_none;

  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_q <= 16'h0000;
      err_q   <= 1'b0;
    end else if (take) begin
      rdata_q <= rsp_value_d;
      err_q   <= rsp_err_d;
    end
  end

  assign rsp_data  = rdata_q;
  assign rsp_error = err_q;

  // --------------------------------------------------------------------
  // Per source enables of mask A
  // --------------------------------------------------------------------
  // Bit 15 is set out of reset, so a pass device fault alerts at once.
  amg_src_type en_a;

  assign en_a.pass_device_fault     =
    alert_mask_a_q[`AMG_EN_PASS_FAULT];
  assign en_a.current_over_fault    =
    alert_mask_a_q[`AMG_EN_CUR_FAULT];
  assign en_a.supply_over_fault     =
    alert_mask_a_q[`AMG_EN_SOV_FAULT];
  assign en_a.supply_under_fault    =
    alert_mask_a_q[`AMG_EN_SUV_FAULT];
  assign en_a.comm_logic_fault      =
    alert_mask_a_q[`AMG_EN_COMM_FAULT];
  assign en_a.current_over_warn     =
    alert_mask_a_q[`AMG_EN_CUR_WARN];
  assign en_a.current_second_warn   =
    alert_mask_a_q[`AMG_EN_CUR2_WARN];
  assign en_a.supply_over_warn      =
    alert_mask_a_q[`AMG_EN_SOV_WARN];
  assign en_a.supply_under_warn     =
    alert_mask_a_q[`AMG_EN_SUV_WARN];
  assign en_a.aux_over_warn         =
    alert_mask_a_q[`AMG_EN_AOV_WARN];
  assign en_a.aux_under_warn        =
    alert_mask_a_q[`AMG_EN_AUV_WARN];
  assign en_a.inrush_limit_fault    =
    alert_mask_a_q[`AMG_EN_INRUSH];
  assign en_a.input_power_over_warn =
    alert_mask_a_q[`AMG_EN_PWR_WARN];

  // --------------------------------------------------------------------
  // Per source enables of mask B
  // --------------------------------------------------------------------
  // All enables of mask B are clear out of reset.
  amg_src_type en_b;

  assign en_b.pass_device_fault     =
    alert_mask_b_q[`AMG_EN_PASS_FAULT];
  assign en_b.current_over_fault    =
    alert_mask_b_q[`AMG_EN_CUR_FAULT];
  assign en_b.supply_over_fault     =
    alert_mask_b_q[`AMG_EN_SOV_FAULT];
  assign en_b.supply_under_fault    =
    alert_mask_b_q[`AMG_EN_SUV_FAULT];
  assign en_b.comm_logic_fault      =
    alert_mask_b_q[`AMG_EN_COMM_FAULT];
  assign en_b.current_over_warn     =
    alert_mask_b_q[`AMG_EN_CUR_WARN];
  assign en_b.current_second_warn   =
    alert_mask_b_q[`AMG_EN_CUR2_WARN];
  assign en_b.supply_over_warn      =
    alert_mask_b_q[`AMG_EN_SOV_WARN];
  assign en_b.supply_under_warn     = alert_mask_b_q[`AMG_EN_SUV_WARN];
  assign en_b.aux_over_warn         = alert_mask_b_q[`AMG_EN_AOV_WARN];
  assign en_b.aux_under_warn        = alert_mask_b_q[`AMG_EN_AUV_WARN];
  assign en_b.inrush_limit_fault    = alert_mask_b_q[`AMG_EN_INRUSH];
  assign en_b.input_power_over_warn = alert_mask_b_q[`AMG_EN_PWR_WARN];

  // --------------------------------------------------------------------
  // Masked sources
  // --------------------------------------------------------------------
  // The status bits are latched upstream, so the alert holds until
  // software clears every enabled bit that is set.
  wire logic [`AMG_SRC_W-1:0] latched_a;
  wire logic [`AMG_SRC_W-1:0] latched_b;
  wire logic [`AMG_SRC_W-1:0] live_a;
  wire logic [`AMG_SRC_W-1:0] live_b;

  assign latched_a = status_latched & en_a;
  assign latched_b = status_latched & en_b;
  assign live_a    = status_live & en_a;
  assign live_b    = status_live & en_b;

  // --------------------------------------------------------------------
  // Pin A causes
  // --------------------------------------------------------------------
  wire logic latched_hit_a = |latched_a;
  wire logic live_hit_a    = |live_a;

  // --------------------------------------------------------------------
  // Pin B causes
  // --------------------------------------------------------------------
  wire logic latched_hit_b = |latched_b;
  wire logic live_hit_b    = |live_b;

  // --------------------------------------------------------------------
  // Function fields and polarity
  // --------------------------------------------------------------------
  // The function field picks alert, plain output, the alternate use of
  // the pin, or comparator; polarity matters only for plain output.
  // A change of function reaches the pin on the edge after the write
  // lands, so the pin may show one cycle of the old function.
  wire logic [1:0] func_a = alert_mask_a_q[`AMG_FUNC_MSB:`AMG_FUNC_LSB];
  wire logic [1:0] func_b = alert_mask_b_q[`AMG_FUNC_MSB:`AMG_FUNC_LSB];
  wire logic       pol_a  = alert_mask_a_q[`AMG_POL_BIT];
  wire logic       pol_b  = alert_mask_b_q[`AMG_POL_BIT];

  assign multipin_a_function = func_a;
  assign multipin_b_function = func_b;

  // --------------------------------------------------------------------
  // Pin A: alert, output, conversion input or comparator
  // --------------------------------------------------------------------
  // In the alternate function pin A is released and read as an input.
  // Its drive stage then keeps the output enable low.
  amg_pin_drive #(
    .ALT_IS_INPUT (1'b1)
  ) u_pin_a (
    .clk          (clk),
    .reset        (reset),
    .function_sel (func_a),
    .polarity     (pol_a),
    .latched_hit  (latched_hit_a),
    .live_hit     (live_hit_a),
    .alt_level    (1'b0),
    .pin          (multipin_a),
    .asserted     (alert_a_active)
  );

  // --------------------------------------------------------------------
  // Pin B: alert, output, retry fail or comparator
  // --------------------------------------------------------------------
  // In the alternate function pin B pulls low while retry has failed.
  // Its drive follows the retry fail input one clock later, through the pin register.
  amg_pin_drive #(
    .ALT_IS_INPUT (1'b0)
  ) u_pin_b (
    .clk          (clk),
    .reset        (reset),
    .function_sel (func_b),
    .polarity     (pol_b),
    .latched_hit  (latched_hit_b),
    .live_hit     (live_hit_b),
    .alt_level    (retry_fail),
    .pin          (multipin_b),
    .asserted     (alert_b_active)
  );

  // --------------------------------------------------------------------
  // Conversion trigger from pin A
  // --------------------------------------------------------------------
  // A rising edge on pin A starts a conversion only in input function.
  // The previous level is cleared while another function is selected,
  // so switching into input mode with the pin high gives one trigger.
  wire logic convert_trigger_in_mode = (func_a == `AMG_FUNC_ALT);
  logic      pin_a_prev_q;
  logic      convert_trigger_in_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      pin_a_prev_q <= 1'b0;
      convert_trigger_in_q       <= 1'b0;
    end else begin
      pin_a_prev_q <= convert_trigger_in_mode & multipin_a_in;
      convert_trigger_in_q       <= convert_trigger_in_mode & multipin_a_in & ~pin_a_prev_q;
    end
  end

  assign convert_trigger_in = convert_trigger_in_q;

endmodule // amg_alert_cfg
`default_nettype wire

/* dv/amg_alert_cfg_props.sv */
// Port assertions for the alert configuration block.
`timescale 1ns/1ps
`default_nettype none
module amg_alert_cfg_props
  import amg_pkg::*;
(
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        cmd_valid,
  input wire amg_cmd_type cmd,
  input wire logic        cmd_ready,
  input wire logic        rsp_valid,
  input wire logic [15:0] rsp_data,
  input wire logic        rsp_error,
  input wire amg_src_type status_latched,
  input wire amg_src_type status_live,
  input wire logic        retry_fail,
  input wire logic        multipin_a_in,
  input wire amg_pin_type multipin_a,
  input wire amg_pin_type multipin_b,
  input wire logic        convert_trigger_in,
  input wire logic        alert_a_active,
  input wire logic        alert_b_active,
  input wire logic [1:0]  multipin_a_function,
  input wire logic [1:0]  multipin_b_function
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  wire take = cmd_valid && cmd_ready;
  wire bad_code = cmd.code != 8'hd5 && cmd.code != 8'hd6;
  sequence s_answer;
    rsp_valid ##1 !rsp_valid;
  endsequence
  property p_rsp; take |=> s_answer; endproperty
  a_rsp: assert property (p_rsp) else $error("answer pulse wrong");
  property p_no_rsp; !take |=> !rsp_valid; endproperty
  a_no_rsp: assert property (p_no_rsp) else $error("stray answer");
  property p_busy; rsp_valid |-> !cmd_ready; endproperty
  a_busy: assert property (p_busy) else $error("ready in answer");
  property p_unmapped;
    take && bad_code |=> rsp_error && rsp_data == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped code");
  property p_gpo; $past(multipin_a_function) == 2'h1 |-> multipin_a.oe;
  endproperty
  a_gpo: assert property (p_gpo) else $error("output not driven");
  property p_convert_trigger_in_off; $past(multipin_a_function) == 2'h2 |-> !multipin_a.oe;
  endproperty
  a_convert_trigger_in_off: assert property (p_convert_trigger_in_off) else $error("input driven");
  property p_convert_trigger_in;
    multipin_a_function == 2'h2 && $rose(multipin_a_in) |-> ##[1:2]
      convert_trigger_in;
  endproperty
  a_convert_trigger_in: assert property (p_convert_trigger_in) else $error("no trigger pulse");
  property p_pulse; convert_trigger_in |=> !convert_trigger_in; endproperty
  a_pulse: assert property (p_pulse) else $error("trigger too long");
  property p_alert_pin;
    $past(multipin_a_function) == 2'h0 |->
      multipin_a.oe == alert_a_active && !multipin_a.out;
  endproperty
  a_alert_pin: assert property (p_alert_pin) else $error("alert pin");
  property p_quiet;
    $past(multipin_a_function) == 2'h0 && $past(status_latched) == '0
      |-> !alert_a_active;
  endproperty
  a_quiet: assert property (p_quiet) else $error("alert no cause");
  property p_live;
    $past(multipin_a_function) == 2'h3 && $past(status_live) == '0
      |-> !alert_a_active;
  endproperty
  a_live: assert property (p_live) else $error("compare no cause");
  property p_retry;
    $past(multipin_b_function) == 2'h2 && $past(retry_fail)
      |-> multipin_b.oe && !multipin_b.out && alert_b_active;
  endproperty
  a_retry: assert property (p_retry) else $error("retry pin");
endmodule // amg_alert_cfg_props
bind amg_alert_cfg amg_alert_cfg_props u_props (.clk(clk), .reset(reset),
  .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
  .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_error(rsp_error),
  .status_latched(status_latched), .status_live(status_live),
  .retry_fail(retry_fail), .multipin_a_in(multipin_a_in),
  .multipin_a(multipin_a), .multipin_b(multipin_b),
  .convert_trigger_in(convert_trigger_in),
  .alert_a_active(alert_a_active), .alert_b_active(alert_b_active),
  .multipin_a_function(multipin_a_function),
  .multipin_b_function(multipin_b_function));
`default_nettype wire

/* dv/amg_host_model.sv */
// Host model issuing decoded commands to the configuration block.
`timescale 1ns/1ps
`default_nettype none
module amg_host_model
  import amg_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        cmd_ready,
  input  wire logic        rsp_valid,
  input  wire logic [15:0] rsp_data,
  input  wire logic        rsp_error,
  output logic             cmd_valid,
  output amg_cmd_type      cmd
);
  initial begin
    cmd_valid = 1'b0;
    cmd = '0;
  end
  task automatic xfer(input logic w, input logic [7:0] c,
    input logic [15:0] d, output logic [15:0] q, output logic e,
    output logic ok);
    int n;
    n = 0;
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd = '{write: w, code: c, data: d};
    while (cmd_ready !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
    @(negedge clk);
    ok = (rsp_valid === 1'b1);
    q = rsp_data;
    e = rsp_error;
    cmd_valid = 1'b0;
    // Released fields carry no stale value.
    cmd = ~cmd;
  endtask
endmodule // amg_host_model
`default_nettype wire

/* dv/amg_alert_cfg_tb_top.sv */
// Testbench for the alert configuration block.
`timescale 1ns/1ps
`default_nettype none
module amg_alert_cfg_tb_top;
  import amg_pkg::*;
  logic        clk, reset, cmd_valid, cmd_ready, rsp_valid, rsp_error;
  logic        retry_fail, multipin_a_in, convert_trigger_in;
  logic        alert_a_active, alert_b_active;
  logic [15:0] rsp_data;
  logic [1:0]  multipin_a_function, multipin_b_function;
  amg_cmd_type cmd;
  amg_src_type status_latched, status_live;
  amg_pin_type multipin_a, multipin_b;
  int          fail_count, tests_run, cycles, i, n;
  amg_alert_cfg u_dut (.clk(clk), .reset(reset), .cmd_valid(cmd_valid),
    .cmd(cmd), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .rsp_error(rsp_error),
    .status_latched(status_latched), .status_live(status_live),
    .retry_fail(retry_fail), .multipin_a_in(multipin_a_in),
    .multipin_a(multipin_a), .multipin_b(multipin_b),
    .convert_trigger_in(convert_trigger_in),
    .alert_a_active(alert_a_active), .alert_b_active(alert_b_active),
    .multipin_a_function(multipin_a_function),
    .multipin_b_function(multipin_b_function));
  amg_host_model u_host (.clk(clk), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_error(rsp_error),
    .cmd_valid(cmd_valid), .cmd(cmd));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] c, input logic [15:0] exp,
    input logic exp_err);
    logic [15:0] q;
    logic        e, ok;
    u_host.xfer(1'b0, c, 16'h0000, q, e, ok);
    chk(q, exp);
    chk(16'({ok, e}), 16'({1'b1, exp_err}));
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    logic [15:0] q;
    logic        e, ok;
    u_host.xfer(1'b1, c, d, q, e, ok);
    chk(16'({ok, e}), 16'({1'b1, (c != 8'hd5) && (c != 8'hd6)}));
  endtask
  task automatic wt(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      conclude();
    end
  end
  initial begin
    reset = 1'b1;
    status_latched = '0;
    status_live = '0;
    retry_fail = 1'b0;
    multipin_a_in = 1'b0;
    wt(8);
    reset = 1'b0;
    wt(1);
    rd(8'hd5, 16'h8000, 1'b0);
    rd(8'hd6, 16'h0004, 1'b0);
    chk(16'(multipin_a_function), 16'h0000);
    chk(16'(multipin_b_function), 16'h0002);
    rd(8'hd7, 16'h0000, 1'b1);
    wr(8'hd7, 16'hffff);
    rd(8'hd5, 16'h8000, 1'b0);
    retry_fail = 1'b1;
    wt(2);
    chk(16'({multipin_b.oe, multipin_b.out}), 16'h0002);
    retry_fail = 1'b0;
    $display("test reset and decode done");
    for (i = 8; i < 16; i++) begin
      wr(8'hd6, 16'h0001 << i);
      rd(8'hd6, 16'h0001 << i, 1'b0);
      status_latched = 13'h0001 << (i - 3);
      wt(2);
      chk(16'({alert_b_active, multipin_b.oe, multipin_b.out}), 16'h0006);
      status_latched = ~(13'h0001 << (i - 3));
      wt(2);
      chk(16'(alert_b_active), 16'h0000);
    end
    $display("test mask b sources done");
    wr(8'hd5, 16'h0008);
    status_latched = 13'h0001;
    wt(2);
    chk(16'({alert_a_active, multipin_a.oe, multipin_a.out}), 16'h0006);
    wt(4);
    chk(16'(alert_a_active), 16'h0001);
    status_latched = '0;
    wt(2);
    chk(16'(alert_a_active), 16'h0000);
    wr(8'hd5, 16'h0000);
    status_latched = 13'h0001;
    wt(2);
    chk(16'(alert_a_active), 16'h0000);
    $display("test latched alert done");
    wr(8'hd5, 16'h0002);
    wt(2);
    chk(16'({multipin_a.oe, multipin_a.out}), 16'h0002);
    wr(8'hd5, 16'h0003);
    wt(2);
    chk(16'({multipin_a.oe, multipin_a.out}), 16'h0003);
    $display("test plain output done");
    wr(8'hd5, 16'h0004);
    wt(2);
    chk(16'(multipin_a.oe), 16'h0000);
    multipin_a_in = 1'b1;
    n = 0;
    repeat (6) begin
      @(negedge clk);
      if (convert_trigger_in === 1'b1)
        n++;
    end
    chk(16'(n), 16'h0001);
    multipin_a_in = 1'b0;
    $display("test convert input done");
    status_latched = '0;
    wr(8'hd5, 16'h000e);
    status_live = 13'h0001;
    wt(2);
    chk(16'({alert_a_active, multipin_a.oe, multipin_a.out}), 16'h0006);
    status_live = '0;
    status_latched = 13'h0001;
    wt(2);
    chk(16'(alert_a_active), 16'h0000);
    $display("test comparator done");
    conclude();
  end
endmodule // amg_alert_cfg_tb_top
`default_nettype wire
